// ### pwd_cfg.svh
/*
 * Timing and counter-width constants of the processor watchdog.
 * Assumes inclusion by bare name from the timer, watchdog and checker modules.
 */
`ifndef PWD_CFG_SVH
`define PWD_CFG_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PWD_CLK_HZ 40000000
`define PWD_TIMEOUT_MS 200
`define PWD_TIMEOUT_CYC ((`PWD_CLK_HZ / 1000) * `PWD_TIMEOUT_MS)
`define PWD_CNT_W 24

`endif

// ### pwd_fw_model.sv
/* Firmware model that services the watchdog.
   Assumes the bench holds gap below the timeout. */
`timescale 1ns/1ps
module pwd_fw_model (
    // Clock
    input wire logic clk,
    // Control
    input wire logic alive,
    input wire logic [7:0] gap,
    // Service line
    output logic service = 1'b0
);
    int n = 0;
    always @(posedge clk) begin
        #1;
        n = (n >= int'(gap) + 2) ? 0 : n + 1;
        service <= alive && n < 2;
    end
endmodule

// ### pwd_pkg.sv
/*
 * Types shared by the processor watchdog modules.
 * Assumes no surroundings beyond the configuration header.
 */
package pwd_pkg;

    // ----------------------------------------------------------------
    // Supervisor states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_DISARMED = 3'h1,
        ST_ARMED = 3'h2,
        ST_TRIPPED = 3'h4
    } pwd_state_type;

endpackage

// ### pwd_tick_if.sv
/*
 * Interface between the watchdog supervisor and its timeout counter.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface pwd_tick_if;
    logic run;
    logic restart;
    logic expired;

    modport ctrl (output run, output restart, input expired);
    modport timer (input run, input restart, output expired);
endinterface

// ### pwd_timer.sv
/*
 * Timeout counter of the processor watchdog.
 * Assumes run and restart come from logic on the same clock.
 */
`timescale 1ns/1ps
`include "pwd_cfg.svh"
module pwd_timer #(
    parameter int unsigned TIMEOUT_CYC = `PWD_TIMEOUT_CYC,
    parameter int unsigned CNT_W = `PWD_CNT_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Supervisor side
    pwd_tick_if.timer tick
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic expired_q;
    logic expired_d;

    always_comb begin
        cnt_d = cnt_q;
        expired_d = 1'b0;
        if (!tick.run || tick.restart) begin
            cnt_d = '0;
        end else if (cnt_q == CNT_W'(TIMEOUT_CYC - 1)) begin
            expired_d = 1'b1;
        end else begin
            cnt_d = cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            expired_q <= 1'b0;
        end else if (clk_en) begin
            cnt_q <= cnt_d;
            expired_q <= expired_d;
        end
    end

    assign tick.expired = expired_q;
endmodule

// ### pwd_watchdog.sv
/*
 * Processor watchdog with latched board reset.
 * Assumes rst_n is the power-on or host reset, and that service and
 * init-done inputs come from the processor domain as asynchronous levels.
 */
`timescale 1ns/1ps
`include "pwd_cfg.svh"

module pwd_watchdog #(
    parameter int unsigned TIMEOUT_CYC = `PWD_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Processor side
    input wire logic init_done,
    input wire logic service,
    // Board outputs
    output logic reset_relay,
    output logic motor_out_en,
    output logic activity_indicator,
    output logic status_relay,
    output logic armed
);
    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [1:0] init_sync_q;
    logic [1:0] init_sync_d;
    logic [1:0] svc_sync_q;
    logic [1:0] svc_sync_d;
    logic svc_last_q;
    logic svc_last_d;
    logic init_seen;
    logic svc_pulse;

    // Only the second stage is read by the logic below, so a first stage
    // caught between levels never reaches a decision.
    always_comb begin
        init_sync_d = {init_sync_q[0], init_done};
        svc_sync_d = {svc_sync_q[0], service};
        svc_last_d = svc_sync_q[1];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            init_sync_q <= 2'h0;
            svc_sync_q <= 2'h0;
            svc_last_q <= 1'b0;
        end else if (clk_en) begin
            init_sync_q <= init_sync_d;
            svc_sync_q <= svc_sync_d;
            svc_last_q <= svc_last_d;
        end
    end

    // A rising edge counts as one service; a stuck-high line does not.
    assign init_seen = init_sync_q[1];
    assign svc_pulse = svc_sync_q[1] & ~svc_last_q;

    // ----------------------------------------------------------------
    // Supervisor
    // ----------------------------------------------------------------
    pwd_pkg::pwd_state_type state_q;
    pwd_pkg::pwd_state_type state_d;
    logic trip_q;
    logic trip_d;

    pwd_tick_if tick ();

    pwd_timer #(
        .TIMEOUT_CYC(TIMEOUT_CYC),
        .CNT_W(`PWD_CNT_W)
    ) i_pwd_timer (
        .clk(clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .tick(tick)
    );

    // The count runs only while armed, and each service edge clears it.
    assign tick.run = (state_q == pwd_pkg::ST_ARMED);
    assign tick.restart = svc_pulse;

    always_comb begin
        state_d = state_q;
        case (state_q)
            pwd_pkg::ST_DISARMED: begin
                if (init_seen) begin
                    state_d = pwd_pkg::ST_ARMED;
                end
            end
            pwd_pkg::ST_ARMED: begin
                if (tick.expired && !svc_pulse) begin
                    state_d = pwd_pkg::ST_TRIPPED;
                end
            end
            // Nothing leaves the trip but rst_n, since firmware cannot be trusted.
            pwd_pkg::ST_TRIPPED: state_d = pwd_pkg::ST_TRIPPED;
            // An upset state code must never release a latched trip.
            default: begin
                state_d = trip_q ? pwd_pkg::ST_TRIPPED : pwd_pkg::ST_DISARMED;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= pwd_pkg::ST_DISARMED;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------------------------------
    // Trip latch
    // ----------------------------------------------------------------
    // A separate sticky flop keeps the trip even if the state register is
    // upset; the cost is one flop, and only rst_n clears it.
    always_comb begin
        trip_d = trip_q;
        if (state_d == pwd_pkg::ST_TRIPPED) begin
            trip_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trip_q <= 1'b0;
        end else if (clk_en) begin
            trip_q <= trip_d;
        end
    end

    // ----------------------------------------------------------------
    // Relay and arm outputs
    // ----------------------------------------------------------------
    logic reset_relay_d;
    logic armed_d;

    always_comb begin
        reset_relay_d = trip_d;
        armed_d = (state_d == pwd_pkg::ST_ARMED);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_relay <= 1'b0;
            armed <= 1'b0;
        end else if (clk_en) begin
            reset_relay <= reset_relay_d;
            armed <= armed_d;
        end
    end

    // ----------------------------------------------------------------
    // Drive enables and indicators
    // ----------------------------------------------------------------
    // All three follow one qualifier: initialised, armed and not tripped.
    logic ready;
    logic motor_out_en_d;
    logic activity_indicator_d;
    logic status_relay_d;

    always_comb begin
        ready = init_seen && (state_d == pwd_pkg::ST_ARMED) && !trip_d;
        motor_out_en_d = ready;
        activity_indicator_d = ready;
        status_relay_d = ready;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            motor_out_en <= 1'b0;
            activity_indicator <= 1'b0;
            status_relay <= 1'b0;
        end else if (clk_en) begin
            motor_out_en <= motor_out_en_d;
            activity_indicator <= activity_indicator_d;
            status_relay <= status_relay_d;
        end
    end
endmodule

// ### pwd_watchdog_props.sv
/* Port checker of the processor watchdog.
   Assumes a bind onto pwd_watchdog. */
`timescale 1ns/1ps
`include "pwd_cfg.svh"
module pwd_watchdog_props #(
    parameter int unsigned TIMEOUT_CYC = `PWD_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Processor side
    input wire logic init_done,
    input wire logic service,
    // Board outputs
    input wire logic reset_relay,
    input wire logic motor_out_en,
    input wire logic activity_indicator,
    input wire logic status_relay,
    input wire logic armed
);
    // The window allows for the two-flop input sync and the output flop.
    localparam int LO = TIMEOUT_CYC - 2;
    localparam int HI = TIMEOUT_CYC + 8;
    // The idle count advances on enabled edges only, as the design's does.
    logic svc_q;
    logic [`PWD_CNT_W-1:0] idle_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            svc_q <= 1'b0;
            idle_q <= '0;
        end else if (clk_en) begin
            svc_q <= service;
            idle_q <= (!armed || (service && !svc_q)) ? '0 : idle_q + 1'b1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    arm_init_a: assert property ($rose(armed) |-> $past(init_done, 2)) else $error("early arm");
    trip_time_a: assert property ($rose(reset_relay) |-> idle_q >= LO && idle_q <= HI)
        else $error("trip at wrong time");
    trip_late_a: assert property (idle_q > HI |-> reset_relay) else $error("no trip");
    trip_hold_a: assert property (reset_relay |=> reset_relay) else $error("trip lost");
    motor_off_a: assert property (motor_out_en |-> armed && !reset_relay) else $error("motor on");
    led_off_a: assert property (reset_relay |-> !activity_indicator) else $error("led on");
    rel_clear_a: assert property ($rose(rst_n) |-> !reset_relay && !armed) else $error("no clear");
    status_ok_a: assert property (status_relay |-> armed && !reset_relay) else $error("relay on");
endmodule

// ### tb_pwd_watchdog.sv
/* Bench of the processor watchdog.
   Assumes the checker and firmware model are compiled first. */
`timescale 1ns/1ps
module tb_pwd_watchdog;
    localparam int unsigned T = 50;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic init_done = 1'b0;
    logic alive = 1'b0;
    logic [7:0] gap = 8'h8;
    logic clk_en = 1'b1;
    logic service;
    logic reset_relay, motor_out_en, activity_indicator, status_relay, armed;
    logic [4:0] exp_q[$];
    logic [4:0] prev = 5'h0;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    int seed = 32'hdd6f27e3;
    initial forever #12.5 clk = ~clk;
    pwd_watchdog #(.TIMEOUT_CYC(T)) i_pwd_watchdog (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
        .init_done(init_done), .service(service), .reset_relay(reset_relay),
        .motor_out_en(motor_out_en), .activity_indicator(activity_indicator),
        .status_relay(status_relay), .armed(armed));
    pwd_fw_model i_pwd_fw_model (.clk(clk), .alive(alive), .gap(gap), .service(service));
    task automatic check(input logic [4:0] seen, input logic [4:0] want);
        n_checks++;
        if (seen !== want) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 2000) begin
            fails++;
            finish_test();
        end
    end
    // Each change of the outputs consumes the oldest note.
    always @(posedge clk) begin
        #2;
        if ({reset_relay, motor_out_en, activity_indicator, status_relay, armed} !== prev) begin
            prev = {reset_relay, motor_out_en, activity_indicator, status_relay, armed};
            check(prev, exp_q.size() ? exp_q.pop_front() : ~prev);
        end
    end
    initial begin
        step(4);
        rst_n = 1'b1;
        exp_q.push_back(5'h0f);
        alive = 1'b1;
        step(20);
        init_done = 1'b1;
        step(10);
        repeat (6) begin
            gap = 8'(4 + {$random(seed)} % (T - 20));
            // Never two stalled edges in a row, so no service pulse is lost.
            repeat (T) begin
                clk_en = !clk_en || ($random(seed) & 1);
                step(1);
            end
        end
        clk_en = 1'b1;
        exp_q.push_back(5'h01);
        init_done = 1'b0;
        step(10);
        exp_q.push_back(5'h0f);
        init_done = 1'b1;
        step(10);
        exp_q.push_back(5'h10);
        alive = 1'b0;
        step(T + 20);
        alive = 1'b1;
        step(T);
        exp_q.push_back(5'h00);
        rst_n = 1'b0;
        step(2);
        exp_q.push_back(5'h0f);
        rst_n = 1'b1;
        step(T);
        check(5'(exp_q.size()), 5'h0);
        finish_test();
    end
endmodule
bind pwd_watchdog pwd_watchdog_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_pwd_watchdog_props (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .init_done(init_done), .service(service),
    .reset_relay(reset_relay), .motor_out_en(motor_out_en),
    .activity_indicator(activity_indicator), .status_relay(status_relay), .armed(armed));
